// ### core/breakpoint_watchpoint_unit.sv
// Breakpoint and watchpoint unit with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "bwu_cfg.svh"
module breakpoint_watchpoint_unit (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // AXI4-Lite slave
  input  wire logic [3:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [3:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Debugger pins
  input  wire logic                 debugAttached,
  input  wire logic                 debugHaltAll,
  // Pipeline side
  input  wire logic [2:0]           curCtx,
  input  wire logic                 softBreakExec,
  input  wire bwu_pkg::access_type  access,
  output bwu_pkg::request_type      request
);
  logic [31:0]          debugCtrl;
  logic [31:0]          modeCtrl;
  logic [31:0]          baseAddr;
  logic                 hitSeen;
  logic [2:0]           hitCtx;
  logic [1:0]           attachSync;
  logic [1:0]           haltAllSync;
  logic [3:0]           wAddr;
  logic [31:0]          wData;
  logic [3:0]           wStrb;
  logic                 doWrite;
  logic [31:0]          wMask;
  logic                 mapped;
  logic                 clearHit;
  logic                 enable;
  logic                 ctxOk;
  logic                 dirOk;
  logic                 addrOk;
  logic                 hit;
  logic [31:0]          blockMask;
  logic [3:0]           sizeCode;
  bwu_pkg::dir_type     dir;
  bwu_pkg::action_type  action;
  logic                 attached;
  logic                 haltAll;
  bwu_pkg::request_type next_request;

  // Debugger pins come from outside the clock domain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      attachSync  <= 2'b00;
      haltAllSync <= 2'b00;
    end else begin
      attachSync  <= {attachSync[0], debugAttached};
      haltAllSync <= {haltAllSync[0], debugHaltAll};
    end
  end
  assign attached = attachSync[1];
  assign haltAll  = haltAllSync[1];

  // Write address and data are taken in either order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      wAddr   <= 4'h0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      wAddr   <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wready <= 1'b1;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wData  <= wdata;
      wStrb  <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  assign doWrite = !awready && !wready && !bvalid;
  assign mapped  = (wAddr[1:0] == 2'b00);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wMask[i*8 +: 8] = {8{wStrb[i]}};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Reserved bits never store, so they read back as zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      debugCtrl <= `RESET_VALUE;
      modeCtrl  <= `RESET_VALUE;
      baseAddr  <= `RESET_VALUE;
    end else if (doWrite) begin
      case (wAddr)
        `OFF_DEBUG_CTRL: begin
          debugCtrl <= ((debugCtrl & ~wMask) | (wData & wMask)) & `DEBUG_CTRL_MASK;
        end
        `OFF_MODE_CTRL: begin
          modeCtrl <= ((modeCtrl & ~wMask) | (wData & wMask)) & `MODE_CTRL_MASK;
        end
        `OFF_BASE_ADDR: begin
          baseAddr <= (baseAddr & ~wMask) | (wData & wMask);
        end
        default: begin
        end
      endcase
    end
  end

  assign clearHit = doWrite && (wAddr == `OFF_STATUS) && wStrb[0] && wData[`STAT_HIT];

  // A hit in the same cycle as the clear wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hitSeen <= 1'b0;
      hitCtx  <= 3'h0;
    end else if (hit) begin
      hitSeen <= 1'b1;
      hitCtx  <= curCtx;
    end else if (clearHit) begin
      hitSeen <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `RESP_OKAY;
      case (araddr)
        `OFF_DEBUG_CTRL: rdata <= debugCtrl;
        `OFF_MODE_CTRL:  rdata <= modeCtrl;
        `OFF_BASE_ADDR:  rdata <= baseAddr;
        `OFF_STATUS: begin
          rdata <= {25'h0, hitCtx, 2'b00, attached, hitSeen};
        end
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Event detector
  assign enable   = modeCtrl[`BIT_ENABLE];
  assign dir      = bwu_pkg::dir_type'(modeCtrl[`POS_DIR +: 2]);
  assign action   = bwu_pkg::action_type'(modeCtrl[`POS_ACTION +: 2]);
  assign sizeCode = modeCtrl[`POS_SIZE +: 4];
  // A misaligned base still watches the aligned block that contains it
  assign blockMask = ~((32'h0000_0001 << sizeCode) - 32'h0000_0001);

  assign ctxOk = !modeCtrl[`BIT_CTX_AWARE] || (curCtx == modeCtrl[`POS_CTX +: 3]);

  always_comb begin
    unique case (dir)
      bwu_pkg::DIR_ANY:   dirOk = 1'b1;
      bwu_pkg::DIR_WRITE: dirOk = access.write;
      bwu_pkg::DIR_READ:  dirOk = !access.write;
      bwu_pkg::DIR_NONE:  dirOk = 1'b0;
    endcase
  end

  always_comb begin
    if (modeCtrl[`BIT_TYPE]) begin
      addrOk = !access.fetch && dirOk && ((access.addr & blockMask) == (baseAddr & blockMask));
    end else begin
      addrOk = access.fetch && (access.addr == baseAddr);
    end
  end

  assign hit = enable && access.valid && ctxOk && addrOk;

  always_comb begin
    next_request         = '0;
    next_request.excCode = `EXC_BREAK;
    next_request.excCtx  = curCtx;
    if (softBreakExec) begin
      if (attached) begin
        next_request.haltCpu = haltAll;
        next_request.haltCtx = !haltAll;
      end else if (debugCtrl[`BIT_SOFT_CTRL]) begin
        next_request.excReq = 1'b1;
      end
    end
    if (hit) begin
      unique case (action)
        bwu_pkg::ACT_TRACE: next_request.traceOn = 1'b1;
        bwu_pkg::ACT_CHAIN: next_request.armNext = 1'b1;
        bwu_pkg::ACT_BREAK: begin
          if (attached) begin
            next_request.haltCpu = next_request.haltCpu | debugCtrl[`BIT_HW_MODE];
            next_request.haltCtx = next_request.haltCtx | !debugCtrl[`BIT_HW_MODE];
          end else begin
            next_request.excReq = 1'b1;
          end
        end
        bwu_pkg::ACT_RESERVED: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      request <= '0;
    end else begin
      request <= next_request;
    end
  end

  // Checks
  sequence writeTaken;
    !awready && !wready && !bvalid;
  endsequence

  // Response rises and, unless the master took it, still stands one cycle later
  sequence respGiven;
    bvalid ##1 ($past(bready) || bvalid);
  endsequence

  chk_write_response: assert property (
    @(posedge clk) disable iff (!nrst) writeTaken |=> respGiven)
    else $error("write not answered next cycle");

  chk_soft_nop: assert property (
    @(posedge clk) disable iff (!nrst)
    softBreakExec && !debugCtrl[`BIT_SOFT_CTRL] && !attached && !hit
    |=> !request.excReq && !request.haltCpu && !request.haltCtx)
    else $error("soft break with control clear did not act as no-op");

  chk_soft_exception: assert property (
    @(posedge clk) disable iff (!nrst)
    softBreakExec && debugCtrl[`BIT_SOFT_CTRL] && !attached
    |=> request.excReq && request.excCode == `EXC_BREAK && request.excCtx == $past(curCtx) && !request.haltCpu)
    else $error("soft break did not raise exception to running context");

  chk_soft_halt: assert property (
    @(posedge clk) disable iff (!nrst)
    softBreakExec && attached && !hit |=> !request.excReq && (request.haltCpu == $past(haltAll))
    && (request.haltCtx != $past(haltAll)))
    else $error("attached soft break did not halt as selected");

  chk_disabled_quiet: assert property (
    @(posedge clk) disable iff (!nrst) !enable |=> !request.traceOn && !request.armNext)
    else $error("disabled detector produced an action");

  chk_trace_chain: assert property (
    @(posedge clk) disable iff (!nrst)
    hit |=> (request.traceOn == ($past(action) == bwu_pkg::ACT_TRACE))
    && (request.armNext == ($past(action) == bwu_pkg::ACT_CHAIN)))
    else $error("trace or chain action mismatched mode");

  chk_break_action: assert property (
    @(posedge clk) disable iff (!nrst)
    hit && action == bwu_pkg::ACT_BREAK && !softBreakExec
    |=> (request.excReq != $past(attached)) && ((request.haltCpu || request.haltCtx) == $past(attached)))
    else $error("break action exception or halt wrong");

  chk_halt_mode: assert property (
    @(posedge clk) disable iff (!nrst)
    hit && action == bwu_pkg::ACT_BREAK && attached && !softBreakExec
    |=> request.haltCpu == $past(debugCtrl[`BIT_HW_MODE]))
    else $error("hardware halt mode bit ignored");

  chk_context_filter: assert property (
    @(posedge clk) disable iff (!nrst)
    hit && modeCtrl[`BIT_CTX_AWARE] |-> curCtx == modeCtrl[`POS_CTX +: 3])
    else $error("trigger in wrong context");

  chk_watch_block: assert property (
    @(posedge clk) disable iff (!nrst)
    hit && modeCtrl[`BIT_TYPE] |-> !access.fetch && (((access.addr ^ baseAddr) >> sizeCode) == 32'h0)
    && dir != bwu_pkg::DIR_NONE)
    else $error("watchpoint hit outside block");

  chk_break_exact: assert property (
    @(posedge clk) disable iff (!nrst)
    access.valid && access.fetch && enable && !modeCtrl[`BIT_TYPE] && ctxOk && access.addr == baseAddr |-> hit)
    else $error("breakpoint missed exact fetch");

  chk_hit_sticky: assert property (
    @(posedge clk) disable iff (!nrst) hit |=> hitSeen [*2] or (hitSeen ##1 !hitSeen))
    else $error("hit flag not recorded");
endmodule

// ### core/bwu_cfg.svh
// Constants of the breakpoint and watchpoint unit
`ifndef BWU_CFG_SVH
`define BWU_CFG_SVH
`define OFF_DEBUG_CTRL   4'h0
`define OFF_MODE_CTRL    4'h4
`define OFF_BASE_ADDR    4'h8
`define OFF_STATUS       4'hc
`define RESET_VALUE      32'h0000_0000
`define DEBUG_CTRL_MASK  32'h0000_0011
`define MODE_CTRL_MASK   32'h0000_f3ff
`define BIT_SOFT_CTRL    0
`define BIT_HW_MODE      4
`define BIT_ENABLE       15
`define POS_DIR          13
`define BIT_CTX_AWARE    12
`define POS_CTX          7
`define BIT_TYPE         6
`define POS_ACTION       4
`define POS_SIZE         0
`define STAT_HIT         0
`define STAT_ATTACHED    1
`define POS_STAT_CTX     4
`define EXC_BREAK        8'h0c
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// ### core/bwu_pkg.sv
// Types shared by the breakpoint and watchpoint unit
package bwu_pkg;
  typedef enum logic [1:0] {
    DIR_ANY   = 2'b00,
    DIR_WRITE = 2'b01,
    DIR_READ  = 2'b10,
    DIR_NONE  = 2'b11
  } dir_type;

  typedef enum logic [1:0] {
    ACT_RESERVED = 2'b00,
    ACT_TRACE    = 2'b01,
    ACT_BREAK    = 2'b10,
    ACT_CHAIN    = 2'b11
  } action_type;

  // One access presented by the pipeline in a cycle
  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic [31:0] addr;
  } access_type;

  // Requests back to the pipeline, registered a cycle after the access or soft break that raises them
  typedef struct packed {
    logic       excReq;
    logic [7:0] excCode;
    logic [2:0] excCtx;
    logic       haltCtx;
    logic       haltCpu;
    logic       traceOn;
    logic       armNext;
  } request_type;
endpackage

// ### tb/pipe_model.sv
// Pipeline and debugger model on the far side of the unit
`timescale 1ns/1ps
module pipe_model (
  // Clock
  input  wire logic                 clk,
  // Towards the unit
  output bwu_pkg::access_type       access,
  output logic [2:0]                curCtx,
  output logic                      softBreakExec,
  output logic                      debugAttached,
  output logic                      debugHaltAll,
  // From the unit
  input  wire bwu_pkg::request_type request
);
  initial begin
    access = '0;
    curCtx = 3'h0;
    softBreakExec = 1'b0;
    debugAttached = 1'b0;
    debugHaltAll = 1'b0;
  end
  // Debugger pins are asynchronous, so give the two-stage sync time to settle
  task automatic attach(input logic a, input logic h);
    @(posedge clk);
    debugAttached <= a;
    debugHaltAll <= h;
    repeat (3) @(posedge clk);
  endtask
  // One access per cycle; released lines show the inverse so a stale value never matches
  task automatic step(input logic sb, input logic v, input logic f, input logic w, input logic [31:0] a,
                      input logic [2:0] c, output bwu_pkg::request_type q);
    @(posedge clk);
    softBreakExec <= sb;
    curCtx <= c;
    access <= '{valid: v, fetch: f, write: w, addr: a};
    @(posedge clk);
    softBreakExec <= 1'b0;
    access <= '{valid: 1'b0, fetch: ~f, write: ~w, addr: ~a};
    #1 q = request;
  endtask
endmodule

// ### tb/tb_breakpoint_watchpoint_unit.sv
// Self-checking bench of the breakpoint and watchpoint unit
`timescale 1ns/1ps
`include "bwu_cfg.svh"
module tb_breakpoint_watchpoint_unit;
  localparam logic [4:0] E = 5'h10, HC = 5'h08, HP = 5'h04, TR = 5'h02, AR = 5'h01;
  logic                 clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [3:0]           awaddr, araddr, wstrb;
  logic [31:0]          wdata, rdata, lastData;
  logic [1:0]           bresp, rresp, lastResp;
  logic [2:0]           curCtx;
  logic                 softBreakExec, debugAttached, debugHaltAll;
  bwu_pkg::access_type  access;
  bwu_pkg::request_type request;
  int                   mismatches, comparisons;

  breakpoint_watchpoint_unit u_dut (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .debugAttached(debugAttached),
    .debugHaltAll(debugHaltAll), .curCtx(curCtx), .softBreakExec(softBreakExec), .access(access),
    .request(request));
  pipe_model u_pipe (.clk(clk), .access(access), .curCtx(curCtx), .softBreakExec(softBreakExec),
    .debugAttached(debugAttached), .debugHaltAll(debugHaltAll), .request(request));

  always #2.5 clk = ~clk;

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic hang;
    mismatches++;
    $display("wrong value bus wait expected answer seen none");
    give_verdict;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit ok;
    ok = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        lastResp = bresp;
        bready <= 1'b0;
        ok = 1;
        break;
      end
    end
    if (!ok) hang();
  endtask
  task automatic rd(input logic [3:0] a);
    bit ok;
    ok = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        lastData = rdata;
        lastResp = rresp;
        rready <= 1'b0;
        ok = 1;
        break;
      end
    end
    if (!ok) hang();
  endtask
  // Exception requests also carry the fixed code and the issuing context
  task automatic hit(input string what, input logic sb, input logic v, input logic f, input logic w,
                     input logic [31:0] a, input logic [2:0] c, input logic [4:0] exp);
    bwu_pkg::request_type q;
    u_pipe.step(sb, v, f, w, a, c, q);
    check(what, {27'h0, q.excReq, q.haltCtx, q.haltCpu, q.traceOn, q.armNext}, {27'h0, exp});
    if (exp[4]) check({what, " ctx"}, {21'h0, q.excCtx, q.excCode}, {21'h0, c, `EXC_BREAK});
  endtask
  function automatic logic [31:0] mc(input logic t, input logic [1:0] dir, input logic aw,
                                     input logic [2:0] cx, input logic [1:0] act, input logic [3:0] sz);
    return {16'h0, 1'b1, dir, aw, 2'b00, cx, t, act, sz};
  endfunction

  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      rd(4'(4 * i));
      check("reset value", lastData, `RESET_VALUE);
    end
    wr(`OFF_DEBUG_CTRL, 32'hffff_ffff);
    rd(`OFF_DEBUG_CTRL);
    check("debug ctrl", lastData, 32'h0000_0011);
    wr(`OFF_MODE_CTRL, 32'hffff_ffff);
    rd(`OFF_MODE_CTRL);
    check("mode ctrl", lastData, 32'h0000_f3ff);
    wr(`OFF_BASE_ADDR, 32'ha5c3_5a3c);
    rd(`OFF_BASE_ADDR);
    check("base", lastData, 32'ha5c3_5a3c);
    wr(4'h2, 32'h0000_0000);
    check("misaligned write", {30'h0, lastResp}, {30'h0, `RESP_SLVERR});
    rd(4'h9);
    check("misaligned read", lastData, 32'h0);
    check("misaligned read resp", {30'h0, lastResp}, {30'h0, `RESP_SLVERR});
    wr(`OFF_DEBUG_CTRL, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_soft;
    wr(`OFF_MODE_CTRL, 32'h0);
    hit("soft nop", 1, 0, 0, 0, 32'h0, 3'h2, 5'h0);
    wr(`OFF_DEBUG_CTRL, 32'h1);
    hit("soft exc", 1, 0, 0, 0, 32'h0, 3'h3, E);
    u_pipe.attach(1'b1, 1'b0);
    hit("soft halt ctx", 1, 0, 0, 0, 32'h0, 3'h1, HC);
    u_pipe.attach(1'b1, 1'b1);
    hit("soft halt cpu", 1, 0, 0, 0, 32'h0, 3'h1, HP);
    u_pipe.attach(1'b0, 1'b0);
    wr(`OFF_DEBUG_CTRL, 32'h0);
    $display("t_soft done");
  endtask
  task automatic t_break;
    wr(`OFF_BASE_ADDR, 32'h0000_1000);
    wr(`OFF_MODE_CTRL, mc(0, 2'b00, 0, 3'h0, 2'b10, 4'h0));
    hit("brk", 0, 1, 1, 0, 32'h0000_1000, 3'h1, E);
    hit("brk next", 0, 1, 1, 0, 32'h0000_1004, 3'h1, 5'h0);
    hit("brk data", 0, 1, 0, 0, 32'h0000_1000, 3'h1, 5'h0);
    rd(`OFF_STATUS);
    check("status", lastData & 32'h73, 32'h11);
    wr(`OFF_STATUS, 32'h1);
    rd(`OFF_STATUS);
    check("status clear", lastData & 32'h1, 32'h0);
    wr(`OFF_DEBUG_CTRL, 32'h10);
    hit("brk hw unattached", 0, 1, 1, 0, 32'h0000_1000, 3'h0, E);
    u_pipe.attach(1'b1, 1'b0);
    hit("brk halt cpu", 0, 1, 1, 0, 32'h0000_1000, 3'h0, HP);
    wr(`OFF_DEBUG_CTRL, 32'h0);
    hit("brk halt ctx", 0, 1, 1, 0, 32'h0000_1000, 3'h0, HC);
    u_pipe.attach(1'b0, 1'b0);
    wr(`OFF_MODE_CTRL, mc(0, 2'b00, 0, 3'h0, 2'b10, 4'h0) & ~32'h8000);
    hit("brk disabled", 0, 1, 1, 0, 32'h0000_1000, 3'h0, 5'h0);
    $display("t_break done");
  endtask
  task automatic t_watch;
    logic [4:0] acts [4];
    acts = '{5'h0, TR, E, AR};
    wr(`OFF_BASE_ADDR, 32'h0000_2000);
    for (int d = 0; d < 4; d++) begin
      wr(`OFF_MODE_CTRL, mc(1, d[1:0], 0, 3'h0, 2'b10, 4'h4));
      for (int w = 0; w < 2; w++) begin
        hit("dir", 0, 1, 0, w[0], 32'h0000_2008, 3'h0, (d == 0 || d == 2 - w) ? E : 5'h0);
      end
    end
    wr(`OFF_MODE_CTRL, mc(1, 2'b00, 0, 3'h0, 2'b10, 4'h4));
    hit("blk top", 0, 1, 0, 0, 32'h0000_200f, 3'h0, E);
    hit("blk above", 0, 1, 0, 1, 32'h0000_2010, 3'h0, 5'h0);
    hit("blk below", 0, 1, 0, 0, 32'h0000_1fff, 3'h0, 5'h0);
    hit("watch fetch", 0, 1, 1, 0, 32'h0000_2000, 3'h0, 5'h0);
    for (int m = 0; m < 4; m++) begin
      wr(`OFF_MODE_CTRL, mc(1, 2'b00, 0, 3'h0, m[1:0], 4'h4));
      hit("action", 0, 1, 0, 1, 32'h0000_2004, 3'h4, acts[m]);
    end
    wr(`OFF_MODE_CTRL, mc(1, 2'b00, 1, 3'h3, 2'b10, 4'h4));
    hit("ctx match", 0, 1, 0, 0, 32'h0000_2000, 3'h3, E);
    hit("ctx other", 0, 1, 0, 0, 32'h0000_2000, 3'h2, 5'h0);
    wr(`OFF_MODE_CTRL, mc(1, 2'b00, 0, 3'h3, 2'b10, 4'h4));
    hit("ctx ignored", 0, 1, 0, 0, 32'h0000_2000, 3'h2, E);
    wr(`OFF_BASE_ADDR, 32'h0001_0000);
    wr(`OFF_MODE_CTRL, mc(1, 2'b00, 0, 3'h0, 2'b10, 4'hf));
    hit("big top", 0, 1, 0, 0, 32'h0001_7fff, 3'h0, E);
    hit("big above", 0, 1, 0, 0, 32'h0001_8000, 3'h0, 5'h0);
    $display("t_watch done");
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr} = 8'h0;
    wstrb = 4'hf;
    wdata = 32'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs;
    t_soft;
    t_break;
    t_watch;
    give_verdict;
  end
endmodule
